// >>> flash_cmd_map.vh
// opcode, status field and sequencing constants of the command decoder
`ifndef FLASH_CMD_MAP_VH
`define FLASH_CMD_MAP_VH
`define NOP_CMD 8'h00
`define WRITE_STATUS_CMD 8'h01
`define PAGE_WRITE_CMD 8'h02
`define NORMAL_READ_CMD 8'h03
`define CLEAR_WRITE_LATCH_CMD 8'h04
`define READ_STATUS_CMD 8'h05
`define SET_WRITE_LATCH_CMD 8'h06
`define FAST_READ_CMD 8'h0b
`define SECTOR_ERASE_CMD 8'h20
`define RESUME_CMD 8'h30
`define ENTER_FOUR_WIRE_CMD 8'h35
`define SINGLE_LOCK_CMD 8'h36
`define QUAD_PAGE_WRITE_CMD 8'h38
`define SINGLE_UNLOCK_CMD 8'h39
`define HALF_BLOCK_ERASE_CMD 8'h52
`define CHIP_ERASE_A_CMD 8'h60
`define ARM_RESET_CMD 8'h66
`define READ_MAKER_DEVICE_CMD 8'h90
`define MEM_RESET_CMD 8'h99
`define READ_IDENT_CMD 8'h9f
`define READ_SIGNATURE_CMD 8'hab
`define SUSPEND_CMD 8'hb0
`define DEEP_SLEEP_CMD 8'hb9
`define DUAL_ADDR_READ_CMD 8'hbb
`define CHIP_ERASE_B_CMD 8'hc7
`define BLOCK_ERASE_CMD 8'hd8
`define QUAD_READ_SHORT_DUMMY_CMD 8'he7
`define QUAD_ADDR_READ_CMD 8'heb
`define EXIT_FOUR_WIRE_CMD 8'hf5
`define FAST_READ_DUMMY 4'h8
`define FOUR_WIRE_FAST_DUMMY 4'h4
`define DUAL_READ_DUMMY 4'h4
`define QUAD_READ_DUMMY 4'h6
`define QUAD_SHORT_DUMMY 4'h4
`define LANES_ONE 3'h1
`define LANES_TWO 3'h2
`define LANES_FOUR 3'h4
`define ADDR_LAST_BYTE 2'h2
`define IDENT_LAST_BYTE 2'h2
`define BUSY_FLAG_BIT 0
`define LATCH_FLAG_BIT 1
`define QUAD_ENABLE_BIT 6
`define LOCK_LOW_BLOCK 8'h00
`define LOCK_HIGH_BLOCK 8'hff
`endif

// >>> sync_stage.v
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module sync_stage #(
    parameter W = 6,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    input wire mclk,
    input wire rst_b,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);
reg [W-1:0] meta_r;

always @(posedge mclk)
begin
    if (!rst_b)
    begin
        meta_r <= INIT;
        q <= INIT;
    end
    else
    begin
        meta_r <= d;
        q <= meta_r;
    end
end
endmodule // sync_stage
`default_nettype wire

// >>> flash_cmd_decoder.v
// serial flash command decoder: opcode, address, dummy and data sequencing
`timescale 1ns/10ps
`default_nettype none
`include "flash_cmd_map.vh"
module flash_cmd_decoder #(
    parameter [7:0] MAKER_ID = 8'h5a, // arbitrary value
    parameter [7:0] DEVICE_TYPE_ID = 8'h3c, // arbitrary value
    parameter [7:0] DEVICE_CAP_ID = 8'h17, // arbitrary value
    parameter [23:0] BUSY_CYCLES = 24'h0007d0
) (
    input wire mclk,
    input wire rst_b,
    input wire chipSelB,
    input wire serialClk,
    input wire [3:0] dataIn,
    output reg [3:0] dataOut,
    output reg [3:0] dataOe,
    output reg [23:0] arrayAddr,
    output reg arrayReadStrobe,
    input wire [7:0] arrayData,
    output reg progStrobe,
    output reg [7:0] progByte,
    output reg opStart,
    output reg [7:0] opCode,
    output reg [23:0] opAddr,
    output reg lockStrobe,
    output reg lockSet,
    output reg lockSector,
    output reg [23:0] lockAddr,
    output reg memReset,
    output reg fourWireCommandMode,
    output reg deepSleep,
    output reg suspended,
    output reg writeEnableLatch,
    output wire writeInProgressFlag,
    output wire quadEnableFlag
);
localparam [2:0] PH_OPC = 3'h0, PH_ADDR = 3'h1, PH_DUM = 3'h2,
    PH_DIN = 3'h3, PH_DOUT = 3'h4, PH_DONE = 3'h5, PH_IGN = 3'h6;
localparam [1:0] CL_CTL = 2'h0, CL_ADR = 2'h1, CL_DIN = 2'h2, CL_RD = 2'h3;

wire [5:0] syncOut;
reg csPrev_r, clkPrev_r;
reg [2:0] phase_r, wid_r, outW_r;
reg [2:0] bitCnt_r;
reg [7:0] shift_r, cmd_r;
reg [5:0] statusNv_r;
reg [23:0] addr_r, busyCnt_r;
reg [1:0] addrCnt_r, outIdx_r, cls_r;
reg [3:0] dumCnt_r, dumNeed_r;
reg [7:0] outShift_r, inByte, nextByte;
reg needLoad_r, gotData_r, armed_r;
reg dOk, dNoAddr, dArr, dWel;
reg [1:0] dCls;
reg [2:0] dAddrW, dOutW;
reg [3:0] dDum;
reg [3:0] sum;
reg [7:0] statusByte;

sync_stage #(.W(6), .INIT(6'h01)) pinSync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d({dataIn, serialClk, chipSelB}),
    .q(syncOut)
);

wire csB = syncOut[0];
wire sclk = syncOut[1];
wire [3:0] din = syncOut[5:2];
wire csFall = csPrev_r & ~csB;
wire csRise = ~csPrev_r & csB;
wire clkRise = ~csB & ~clkPrev_r & sclk;
wire clkFall = ~csB & clkPrev_r & ~sclk;
wire byteEnd = sum[3];
wire boundary = (bitCnt_r == 3'h0);

assign writeInProgressFlag = (busyCnt_r != 24'h0) & ~suspended;
assign quadEnableFlag = statusNv_r[`QUAD_ENABLE_BIT - 2];

always @*
begin
    statusByte = {statusNv_r, 2'b00};
    statusByte[`BUSY_FLAG_BIT] = writeInProgressFlag;
    statusByte[`LATCH_FLAG_BIT] = writeEnableLatch;
    sum = {1'b0, bitCnt_r} + {1'b0, wid_r};
    if (wid_r == `LANES_ONE)
        inByte = {shift_r[6:0], din[0]};
    else if (wid_r == `LANES_TWO)
        inByte = {shift_r[5:0], din[1:0]};
    else
        inByte = {shift_r[3:0], din};
    case (cmd_r)
        `READ_STATUS_CMD: nextByte = statusByte;
        `READ_IDENT_CMD: nextByte = (outIdx_r == 2'h0) ? MAKER_ID :
            (outIdx_r == 2'h1) ? DEVICE_TYPE_ID : DEVICE_CAP_ID;
        `READ_MAKER_DEVICE_CMD: nextByte = (outIdx_r[0] ^ addr_r[0]) ?
            DEVICE_CAP_ID : MAKER_ID;
        `READ_SIGNATURE_CMD: nextByte = DEVICE_CAP_ID;
        default: nextByte = arrayData;
    endcase
end

// opcode decode of the byte just completed
always @*
begin
    dOk = 1'b1;
    dCls = CL_CTL;
    dNoAddr = 1'b0;
    dArr = 1'b0;
    dWel = 1'b0;
    dAddrW = fourWireCommandMode ? `LANES_FOUR : `LANES_ONE;
    dOutW = dAddrW;
    dDum = 4'h0;
    case (inByte)
        `SET_WRITE_LATCH_CMD, `CLEAR_WRITE_LATCH_CMD, `DEEP_SLEEP_CMD,
        `SUSPEND_CMD, `RESUME_CMD, `ARM_RESET_CMD, `MEM_RESET_CMD,
        `ENTER_FOUR_WIRE_CMD, `EXIT_FOUR_WIRE_CMD, `NOP_CMD:
            dCls = CL_CTL;
        `CHIP_ERASE_A_CMD, `CHIP_ERASE_B_CMD:
        begin
            dArr = 1'b1;
            dWel = 1'b1;
        end
        `READ_STATUS_CMD:
        begin
            dCls = CL_RD;
            dNoAddr = 1'b1;
        end
        `READ_IDENT_CMD:
        begin
            dCls = CL_RD;
            dNoAddr = 1'b1;
            dArr = 1'b1;
        end
        `READ_MAKER_DEVICE_CMD, `READ_SIGNATURE_CMD:
            dCls = CL_RD;
        `WRITE_STATUS_CMD:
        begin
            dCls = CL_DIN;
            dNoAddr = 1'b1;
            dArr = 1'b1;
            dWel = 1'b1;
        end
        `PAGE_WRITE_CMD, `QUAD_PAGE_WRITE_CMD:
        begin
            dCls = CL_DIN;
            dArr = 1'b1;
            dWel = 1'b1;
            if (inByte == `QUAD_PAGE_WRITE_CMD)
            begin
                dAddrW = `LANES_FOUR;
                dOk = fourWireCommandMode | quadEnableFlag;
            end
        end
        `SECTOR_ERASE_CMD, `HALF_BLOCK_ERASE_CMD, `BLOCK_ERASE_CMD:
        begin
            dCls = CL_ADR;
            dArr = 1'b1;
            dWel = 1'b1;
        end
        `SINGLE_LOCK_CMD, `SINGLE_UNLOCK_CMD:
        begin
            dCls = CL_ADR;
            dArr = 1'b1;
        end
        `NORMAL_READ_CMD:
        begin
            dCls = CL_RD;
            dArr = 1'b1;
        end
        `FAST_READ_CMD:
        begin
            dCls = CL_RD;
            dArr = 1'b1;
            dDum = fourWireCommandMode ? `FOUR_WIRE_FAST_DUMMY :
                `FAST_READ_DUMMY;
        end
        `DUAL_ADDR_READ_CMD:
        begin
            dCls = CL_RD;
            dArr = 1'b1;
            dAddrW = `LANES_TWO;
            dOutW = `LANES_TWO;
            dDum = `DUAL_READ_DUMMY;
            dOk = ~fourWireCommandMode;
        end
        `QUAD_ADDR_READ_CMD, `QUAD_READ_SHORT_DUMMY_CMD:
        begin
            dCls = CL_RD;
            dArr = 1'b1;
            dAddrW = `LANES_FOUR;
            dOutW = `LANES_FOUR;
            dDum = (inByte == `QUAD_ADDR_READ_CMD) ? `QUAD_READ_DUMMY :
                `QUAD_SHORT_DUMMY;
            dOk = fourWireCommandMode | quadEnableFlag;
        end
        default:
            dOk = 1'b0;
    endcase
    if (dArr & writeInProgressFlag)
        dOk = 1'b0;
    if (dWel & ~writeEnableLatch)
        dOk = 1'b0;
    if (deepSleep & (inByte != `READ_SIGNATURE_CMD) &
        (inByte != `ARM_RESET_CMD) & (inByte != `MEM_RESET_CMD))
        dOk = 1'b0;
end

always @(posedge mclk)
begin
    if (!rst_b)
    begin
        csPrev_r <= 1'b1;
        clkPrev_r <= 1'b0;
        phase_r <= PH_IGN;
        wid_r <= `LANES_ONE;
        outW_r <= `LANES_ONE;
        bitCnt_r <= 3'h0;
        shift_r <= 8'h00;
        cmd_r <= 8'h00;
        statusNv_r <= 6'h00;
        addr_r <= 24'h000000;
        busyCnt_r <= 24'h000000;
        addrCnt_r <= 2'h0;
        outIdx_r <= 2'h0;
        cls_r <= CL_CTL;
        dumCnt_r <= 4'h0;
        dumNeed_r <= 4'h0;
        outShift_r <= 8'h00;
        needLoad_r <= 1'b0;
        gotData_r <= 1'b0;
        armed_r <= 1'b0;
        dataOut <= 4'h0;
        dataOe <= 4'h0;
        arrayAddr <= 24'h000000;
        arrayReadStrobe <= 1'b0;
        progStrobe <= 1'b0;
        progByte <= 8'h00;
        opStart <= 1'b0;
        opCode <= 8'h00;
        opAddr <= 24'h000000;
        lockStrobe <= 1'b0;
        lockSet <= 1'b0;
        lockSector <= 1'b0;
        lockAddr <= 24'h000000;
        memReset <= 1'b0;
        fourWireCommandMode <= 1'b0;
        deepSleep <= 1'b0;
        suspended <= 1'b0;
        writeEnableLatch <= 1'b0;
    end
    else
    begin
        csPrev_r <= csB;
        clkPrev_r <= sclk;
        arrayReadStrobe <= 1'b0;
        progStrobe <= 1'b0;
        opStart <= 1'b0;
        lockStrobe <= 1'b0;
        memReset <= 1'b0;
        if (writeInProgressFlag)
        begin
            busyCnt_r <= busyCnt_r - 24'h000001;
            if (busyCnt_r == 24'h000001)
                writeEnableLatch <= 1'b0;
        end
        if (csFall)
        begin
            phase_r <= PH_OPC;
            wid_r <= fourWireCommandMode ? `LANES_FOUR : `LANES_ONE;
            bitCnt_r <= 3'h0;
            addrCnt_r <= 2'h0;
            dumCnt_r <= 4'h0;
            gotData_r <= 1'b0;
        end
        else if (csRise)
        begin
            phase_r <= PH_IGN;
            dataOe <= 4'h0;
            needLoad_r <= 1'b0;
            armed_r <= 1'b0;
            if (boundary & ((phase_r == PH_DONE) |
                ((phase_r == PH_DIN) & gotData_r)))
            begin
                case (cmd_r)
                    `SET_WRITE_LATCH_CMD: writeEnableLatch <= 1'b1;
                    `CLEAR_WRITE_LATCH_CMD:
                        writeEnableLatch <= 1'b0;
                    `DEEP_SLEEP_CMD: deepSleep <= 1'b1;
                    `SUSPEND_CMD:
                        if (writeInProgressFlag)
                        begin
                            suspended <= 1'b1;
                            writeEnableLatch <= 1'b0;
                        end
                    `RESUME_CMD: suspended <= 1'b0;
                    `ARM_RESET_CMD: armed_r <= 1'b1;
                    `MEM_RESET_CMD:
                        if (armed_r)
                        begin
                            memReset <= 1'b1;
                            writeEnableLatch <= 1'b0;
                            fourWireCommandMode <= 1'b0;
                            deepSleep <= 1'b0;
                            suspended <= 1'b0;
                            busyCnt_r <= 24'h000000;
                        end
                    `ENTER_FOUR_WIRE_CMD: fourWireCommandMode <= 1'b1;
                    `EXIT_FOUR_WIRE_CMD: fourWireCommandMode <= 1'b0;
                    `SINGLE_LOCK_CMD, `SINGLE_UNLOCK_CMD:
                    begin
                        lockStrobe <= 1'b1;
                        lockSet <= (cmd_r == `SINGLE_LOCK_CMD);
                        lockSector <= (addr_r[23:16] == `LOCK_LOW_BLOCK) |
                            (addr_r[23:16] == `LOCK_HIGH_BLOCK);
                        lockAddr <= ((addr_r[23:16] == `LOCK_LOW_BLOCK) |
                            (addr_r[23:16] == `LOCK_HIGH_BLOCK)) ?
                            {addr_r[23:12], 12'h000} :
                            {addr_r[23:16], 16'h0000};
                    end
                    `NOP_CMD: armed_r <= 1'b0;
                    default:
                    begin
                        opStart <= 1'b1;
                        opCode <= cmd_r;
                        opAddr <= addr_r;
                        busyCnt_r <= BUSY_CYCLES;
                        if (cmd_r == `WRITE_STATUS_CMD)
                            statusNv_r <= progByte[7:2];
                    end
                endcase
            end
        end
        else if (clkRise & (phase_r != PH_IGN) & (phase_r != PH_DOUT))
        begin
            shift_r <= inByte;
            bitCnt_r <= sum[2:0];
            if (phase_r == PH_DUM)
            begin
                dumCnt_r <= dumCnt_r + 4'h1;
                if (dumCnt_r + 4'h1 == dumNeed_r)
                    phase_r <= PH_DOUT;
            end
            if (byteEnd)
            begin
                case (phase_r)
                    PH_OPC:
                    begin
                        cmd_r <= inByte;
                        cls_r <= dCls;
                        outW_r <= dOutW;
                        dumNeed_r <= dDum;
                        wid_r <= dAddrW;
                        outIdx_r <= 2'h0;
                        if (!dOk)
                            phase_r <= PH_IGN;
                        else if (dCls == CL_CTL)
                            phase_r <= PH_DONE;
                        else if (!dNoAddr)
                            phase_r <= PH_ADDR;
                        else if (dCls == CL_DIN)
                            phase_r <= PH_DIN;
                        else
                            phase_r <= PH_DOUT;
                        if (dOk & (inByte == `READ_SIGNATURE_CMD))
                            deepSleep <= 1'b0;
                    end
                    PH_ADDR:
                    begin
                        addr_r <= {addr_r[15:0], inByte};
                        addrCnt_r <= addrCnt_r + 2'h1;
                        if (addrCnt_r == `ADDR_LAST_BYTE)
                        begin
                            if (cls_r == CL_ADR)
                                phase_r <= PH_DONE;
                            else if (cls_r == CL_DIN)
                                phase_r <= PH_DIN;
                            else if (dumNeed_r != 4'h0)
                                phase_r <= PH_DUM;
                            else
                                phase_r <= PH_DOUT;
                        end
                    end
                    PH_DIN:
                    begin
                        gotData_r <= 1'b1;
                        progByte <= inByte;
                        progStrobe <= (cmd_r != `WRITE_STATUS_CMD);
                    end
                    // dummy phase may end on a byte end: leave phase alone
                    default:
                        ;
                endcase
            end
        end
        else if (clkFall & (phase_r == PH_DOUT) & ~needLoad_r)
        begin
            if (outW_r == `LANES_ONE)
                dataOut <= {2'b00, outShift_r[7], 1'b0};
            else if (outW_r == `LANES_TWO)
                dataOut <= {2'b00, outShift_r[7:6]};
            else
                dataOut <= outShift_r[7:4];
            dataOe <= (outW_r == `LANES_ONE) ? 4'h2 :
                (outW_r == `LANES_TWO) ? 4'h3 : 4'hf;
            outShift_r <= outShift_r << outW_r;
            bitCnt_r <= bitCnt_r + outW_r;
            if ({1'b0, bitCnt_r} + {1'b0, outW_r} == 4'h8)
            begin
                needLoad_r <= 1'b1;
                arrayAddr <= arrayAddr + 24'h000001;
                outIdx_r <= (outIdx_r == `IDENT_LAST_BYTE) ? 2'h0 :
                    outIdx_r + 2'h1;
            end
        end
        if (~csFall & ~csRise & clkRise & (phase_r != PH_DOUT) &
            (phase_r != PH_IGN) & (((phase_r == PH_DUM) &
            (dumCnt_r + 4'h1 == dumNeed_r)) | (byteEnd &
            (((phase_r == PH_OPC) & dOk & dNoAddr & (dCls == CL_RD)) |
            ((phase_r == PH_ADDR) & (addrCnt_r == `ADDR_LAST_BYTE) &
            (cls_r == CL_RD) & (dumNeed_r == 4'h0))))))
        begin
            needLoad_r <= 1'b1;
            bitCnt_r <= 3'h0;
            arrayAddr <= (phase_r == PH_ADDR) ? {addr_r[15:0], inByte} :
                addr_r;
        end
        else if (needLoad_r & ~clkFall & ~csRise & ~csFall)
        begin
            outShift_r <= nextByte;
            needLoad_r <= 1'b0;
            arrayReadStrobe <= (cmd_r != `READ_STATUS_CMD) &
                (cmd_r != `READ_IDENT_CMD) &
                (cmd_r != `READ_MAKER_DEVICE_CMD) &
                (cmd_r != `READ_SIGNATURE_CMD);
        end
    end
end
endmodule // flash_cmd_decoder
`default_nettype wire

// >>> flash_host_model.sv
// host controller model driving the serial flash link
`timescale 1ns/10ps
`default_nettype none
module flash_host_model (
    input wire logic mclk,
    input wire logic [3:0] dataOut,
    input wire logic [3:0] dataOe,
    output logic chipSelB,
    output logic serialClk,
    output wire logic [3:0] dataIn
);
    logic [3:0] drv = 4'h0;
    logic cpol = 1'b0;
    // line level from both parties
    assign dataIn = (dataOe & dataOut) | (~dataOe & drv);
    initial
    begin
        chipSelB = 1'b1;
        serialClk = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic frameBegin(input logic mode3);
        cpol = mode3;
        serialClk <= mode3;
        tick(4);
        chipSelB <= 1'b0;
        tick(4);
    endtask
    // one byte; lanes 2 gives four clocks only
    task automatic xfer(input logic [7:0] tx, input int lanes,
        output logic [7:0] rx);
        logic [7:0] sh;
        sh = tx;
        rx = 8'h00;
        for (int k = 0; k < 8 / lanes; k++)
        begin
            serialClk <= 1'b0;
            // launch on falling edge, msb first
            if (lanes == 1)
                drv <= {~drv[3:1], sh[7]};
            else
                drv <= sh[7:4];
            sh = sh << lanes;
            tick(4);
            serialClk <= 1'b1;
            tick(4);
            // device bit taken late in high phase
            rx = (lanes == 1) ? {rx[6:0], dataIn[1]} : {rx[3:0], dataIn};
        end
    endtask
    task automatic frameEnd();
        tick(4);
        serialClk <= cpol;
        tick(4);
        chipSelB <= 1'b1;
        drv <= ~drv;
        tick(8);
    endtask
endmodule // flash_host_model
`default_nettype wire

// >>> flash_cmd_decoder_assertions.sv
// checker for the command decoder ports
`timescale 1ns/10ps
`default_nettype none
module flash_cmd_decoder_checker #(
    parameter [23:0] BUSY_CYCLES = 24'h0007d0
) (
    input wire mclk,
    input wire rst_b,
    input wire chipSelB,
    input wire [3:0] dataOe,
    input wire opStart,
    input wire memReset,
    input wire suspended,
    input wire fourWireCommandMode,
    input wire writeEnableLatch,
    input wire writeInProgressFlag
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic [23:0] busyLen_r;
    always @(posedge mclk)
        busyLen_r <= (!rst_b || !writeInProgressFlag) ? 24'h0 :
            busyLen_r + 24'h1;
    oe_idle_a: assert property (chipSelB [*6] |-> dataOe == 4'h0)
        else $error("output enabled while deselected");
    oe_frame_a: assert property ($fell(dataOe[1]) |-> chipSelB)
        else $error("output dropped inside frame");
    start_latch_a: assert property (opStart |-> $past(writeEnableLatch))
        else $error("operation started with latch clear");
    busy_start_a: assert property (opStart |-> ##[1:2] writeInProgressFlag)
        else $error("busy not raised");
    busy_max_a: assert property (busyLen_r <= BUSY_CYCLES + 1)
        else $error("busy too long");
    busy_len_a: assert property ($fell(writeInProgressFlag) && !suspended &&
        !memReset && !$past(memReset) |->
        $past(busyLen_r) >= BUSY_CYCLES - 1)
        else $error("busy too short");
    latch_done_a: assert property ($fell(writeInProgressFlag) |->
        ##[0:2] !writeEnableLatch)
        else $error("latch kept after operation");
    latch_set_a: assert property ($rose(writeEnableLatch) |-> chipSelB)
        else $error("latch set inside frame");
    quad_on_a: assert property ($changed(fourWireCommandMode) |-> chipSelB)
        else $error("mode changed inside frame");
    reset_eff_a: assert property (memReset |-> chipSelB ##[0:2]
        (!writeEnableLatch && !fourWireCommandMode))
        else $error("memory reset incomplete");
    cover property (opStart);
    cover property (memReset);
    cover property ($rose(fourWireCommandMode));
    cover property ($rose(dataOe[1]));
endmodule // flash_cmd_decoder_checker
bind flash_cmd_decoder flash_cmd_decoder_checker #(.BUSY_CYCLES(BUSY_CYCLES))
    flash_cmd_decoder_checker_i (.*);
`default_nettype wire

// >>> serial_flash_command_decoder_tb.sv
// self-checking bench of the command decoder
`timescale 1ns/10ps
`default_nettype none
module serial_flash_command_decoder_tb;
    localparam [23:0] BUSY = 24'h0003e8;
    localparam [7:0] MK = 8'h4d; // arbitrary value
    localparam [7:0] TY = 8'h21; // arbitrary value
    localparam [7:0] CP = 8'h0e; // arbitrary value
    logic mclk, rst_b, oeSeen, opStart, memReset, fourWireCommandMode;
    logic writeEnableLatch, writeInProgressFlag;
    logic [7:0] arrayData, rx, opCode, progByte;
    logic [3:0] dataOut, dataOe;
    logic [23:0] arrayAddr, opAddr;
    wire logic chipSelB;
    wire logic serialClk;
    wire logic [3:0] dataIn;
    int error_cnt = 0, tests_run = 0, starts = 0, resets = 0;
    assign arrayData = arrayAddr[7:0] ^ 8'ha5;
    flash_host_model flash_host_model_i (.mclk(mclk), .dataOut(dataOut),
        .dataOe(dataOe), .chipSelB(chipSelB), .serialClk(serialClk),
        .dataIn(dataIn));
    flash_cmd_decoder #(.MAKER_ID(MK), .DEVICE_TYPE_ID(TY),
        .DEVICE_CAP_ID(CP), .BUSY_CYCLES(BUSY)) flash_cmd_decoder_i (
        .mclk(mclk), .rst_b(rst_b), .chipSelB(chipSelB),
        .serialClk(serialClk), .dataIn(dataIn), .dataOut(dataOut),
        .dataOe(dataOe), .arrayAddr(arrayAddr), .arrayReadStrobe(),
        .arrayData(arrayData), .progStrobe(), .progByte(progByte),
        .opStart(opStart), .opCode(opCode), .opAddr(opAddr),
        .lockStrobe(), .lockSet(), .lockSector(), .lockAddr(),
        .memReset(memReset), .fourWireCommandMode(fourWireCommandMode),
        .deepSleep(), .suspended(), .writeEnableLatch(writeEnableLatch),
        .writeInProgressFlag(writeInProgressFlag), .quadEnableFlag());
    initial
    begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        if (opStart === 1'b1) starts++;
        if (memReset === 1'b1) resets++;
        if (dataOe !== 4'h0) oeSeen = 1'b1;
    end
    task automatic chk(input string nm, input logic [23:0] e, g);
        tests_run++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    task automatic frame(input logic [7:0] a, b, c, d, input int n,
        input int lanes, input logic m3);
        logic [7:0] q [4];
        q = '{a, b, c, d};
        flash_host_model_i.frameBegin(m3);
        for (int i = 0; i < n; i++) flash_host_model_i.xfer(q[i], lanes, rx);
        flash_host_model_i.frameEnd();
    endtask
    task automatic t_latch();
        frame(8'h06, 0, 0, 0, 1, 1, 0);
        chk("wel", 1, writeEnableLatch);
        frame(8'h05, 8'hff, 0, 0, 2, 1, 0);
        chk("status", 8'h02, rx);
        frame(8'h04, 0, 0, 0, 1, 1, 0);
        chk("wel", 0, writeEnableLatch);
        frame(8'h06, 0, 0, 0, 1, 2, 0);
        chk("wel", 0, writeEnableLatch);
        oeSeen = 1'b0;
        frame(8'h77, 8'h00, 0, 0, 2, 1, 0);
        chk("oe", 0, oeSeen);
    endtask
    task automatic t_prog();
        logic [7:0] pg [5] = '{8'h02, 8'h12, 8'h34, 8'h56, 8'hc3};
        frame(8'h02, 8'h12, 8'h34, 8'h56, 4, 1, 0);
        chk("starts", 0, starts);
        frame(8'h06, 0, 0, 0, 1, 1, 0);
        flash_host_model_i.frameBegin(0);
        for (int i = 0; i < 5; i++) flash_host_model_i.xfer(pg[i], 1, rx);
        flash_host_model_i.frameEnd();
        chk("starts", 1, starts);
        chk("op", 8'h02, opCode);
        chk("addr", 24'h123456, opAddr);
        chk("data", 8'hc3, progByte);
        frame(8'h05, 8'hff, 0, 0, 2, 1, 0);
        chk("status", 8'h03, rx);
        oeSeen = 1'b0;
        frame(8'h03, 8'h00, 8'h00, 8'h00, 4, 1, 0);
        frame(8'h9f, 8'h00, 0, 0, 2, 1, 0);
        chk("oe", 0, oeSeen);
        flash_host_model_i.tick(BUSY);
        chk("wip", 0, writeInProgressFlag);
        chk("wel", 0, writeEnableLatch);
    endtask
    task automatic t_ident();
        flash_host_model_i.frameBegin(1);
        flash_host_model_i.xfer(8'h9f, 1, rx);
        for (int i = 0; i < 3; i++)
        begin
            flash_host_model_i.xfer(8'h00, 1, rx);
            chk("ident", i == 0 ? MK : i == 1 ? TY : CP, rx);
        end
        flash_host_model_i.frameEnd();
        for (int a = 0; a < 2; a++)
        begin
            flash_host_model_i.frameBegin(0);
            for (int i = 0; i < 4; i++)
                flash_host_model_i.xfer(i == 0 ? 8'h90 :
                    i == 3 ? a[7:0] : 8'h00, 1, rx);
            flash_host_model_i.xfer(8'h00, 1, rx);
            chk("maker dev", a ? CP : MK, rx);
            flash_host_model_i.xfer(8'h00, 1, rx);
            chk("maker dev", a ? MK : CP, rx);
            flash_host_model_i.frameEnd();
        end
    endtask
    task automatic t_read();
        frame(8'h03, 8'h00, 8'h01, 8'h0f, 4, 1, 0);
        for (int c = 0; c < 2; c++)
        begin
            flash_host_model_i.frameBegin(0);
            for (int i = 0; i < 4 + c; i++)
                flash_host_model_i.xfer(i == 0 ? (c ? 8'h0b : 8'h03) :
                    i == 3 ? 8'h0f : 8'h00, 1, rx);
            flash_host_model_i.xfer(8'h00, 1, rx);
            chk("rd0", 8'h0f ^ 8'ha5, rx);
            flash_host_model_i.xfer(8'h00, 1, rx);
            chk("rd1", 8'h10 ^ 8'ha5, rx);
            flash_host_model_i.frameEnd();
        end
    endtask
    task automatic t_reset();
        frame(8'h66, 0, 0, 0, 1, 1, 0);
        frame(8'h99, 0, 0, 0, 1, 1, 0);
        chk("reset", 1, resets);
        frame(8'h66, 0, 0, 0, 1, 1, 0);
        frame(8'h05, 8'hff, 0, 0, 2, 1, 0);
        frame(8'h99, 0, 0, 0, 1, 1, 0);
        chk("reset", 1, resets);
    endtask
    task automatic t_quad();
        frame(8'h35, 0, 0, 0, 1, 1, 0);
        chk("quad", 1, fourWireCommandMode);
        frame(8'h06, 0, 0, 0, 1, 4, 0);
        frame(8'h05, 8'hff, 0, 0, 2, 4, 0);
        chk("status", 8'h02, rx);
        flash_host_model_i.frameBegin(0);
        for (int i = 0; i < 8; i++)
            flash_host_model_i.xfer(i == 0 ? 8'heb : i == 3 ? 8'h0f : 8'h00,
                4, rx);
        chk("quad rd", 8'h0f ^ 8'ha5, rx);
        flash_host_model_i.frameEnd();
        frame(8'h04, 0, 0, 0, 1, 4, 0);
        frame(8'hf5, 0, 0, 0, 1, 4, 0);
        chk("quad", 0, fourWireCommandMode);
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        #3000000;
        error_cnt++;
        wrap_up();
    end
    initial
    begin
        rst_b = 1'b0;
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        flash_host_model_i.tick(4);
        t_latch();
        t_prog();
        t_ident();
        t_read();
        t_reset();
        t_quad();
        wrap_up();
    end
endmodule // serial_flash_command_decoder_tb
`default_nettype wire
